/* hdl/mppio_port.sv */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - select bit 0 port, 1 alternate
// - bits 15..8 pick address 31..24
// - pins 15..10 configurable independently of 9..8
// - bit 7 picks transfer-in-progress output
// - transfer-in-progress follows transfers one clock later, stays high back-to-back
// - bits 6..5 pick dma request inputs
// - bits 4..2 pick modifier or dma acknowledge
// - modifier low cpu space, level on iack
// - bits 1..0 pick transfer type outputs
// - direction 0 input, 1 output
// - direction ignored on alternate pins
// - data register ignored on alternate pins
// - input pin read returns sampled level
// - input pin write stores without pin change
// - output pin driven by stored bit, read back
// - data register writable at any time
// - registers reachable by external bus masters
// - sixteen pins, each select, direction, data
module mppio_port
    import mppio_pkg::*;
#(
    parameter int unsigned NPINS = PIN_COUNT // pin count
) (
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    // register access port: internal or external master
    input  wire logic             i_reg_sel,
    input  wire logic             i_reg_wr,
    input  wire logic [11:0]      i_reg_addr,
    input  wire logic [1:0]       i_reg_be,
    input  wire logic [15:0]      i_reg_wdata,
    output logic      [15:0]      o_reg_rdata,
    output logic                  o_reg_ack,
    output logic                  o_reg_err,
    // alternate bus functions from the bus controller
    input  wire logic [7:0]       i_alt_addr_hi,
    input  wire logic             i_bus_xfer_active,
    input  wire logic             i_bus_owned,
    input  wire logic             i_cpu_space,
    input  wire logic             i_int_ack,
    input  wire logic [2:0]       i_int_level,
    input  wire logic [2:0]       i_xfer_modifier,
    input  wire logic [1:0]       i_dma_ack_en,
    input  wire logic [1:0]       i_dma_ack,
    input  wire logic             i_bus_master,
    input  wire logic [1:0]       i_xfer_type,
    output logic      [1:0]       o_dma_request_in,
    output logic      [NPINS-1:0] o_pin_function_select,
    // pad signals
    input  wire logic [NPINS-1:0] i_port_pin,
    output logic      [NPINS-1:0] o_port_pin,
    output logic      [NPINS-1:0] o_port_pin_oe
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [NPINS-1:0] sel_q;   // function select
    logic [NPINS-1:0] dir_q;   // direction
    logic [NPINS-1:0] dat_q;   // stored data
    logic [NPINS-1:0] pin_s;   // synchronised pin levels
    logic             tip_q;   // transfer in progress, registered
    logic [15:0]      rdata_q; // read data
    logic             ack_q;   // access answer
    logic             err_q;   // unmapped access

    // ************************************************************
    // address decode
    // ************************************************************
    wire hit_sel = i_reg_addr == OFS_PIN_FUNCTION_SELECT;
    wire hit_dir = i_reg_addr == OFS_PORT_DIRECTION;
    wire hit_dat = i_reg_addr == OFS_PORT_DATA;
    wire hit_any = hit_sel | hit_dir | hit_dat;
    // byte lane write mask
    wire [15:0] be_mask = {{8{i_reg_be[1]}}, {8{i_reg_be[0]}}};
    // access strobes, same path for any bus master
    wire wr_en = i_reg_sel & i_reg_wr;
    wire rd_en = i_reg_sel & ~i_reg_wr;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_sync
            // one two-flop stage per pin
            mppio_sync u_sync (
                .i_clk   (i_clk),
                .i_srst  (i_srst),
                .i_async (i_port_pin[g]),
                .o_sync  (pin_s[g])
            );
        end
    endgenerate

    // ************************************************************
    // readback value for the data register
    // ************************************************************
    // port inputs show the pin, port outputs show the stored bit
    wire [NPINS-1:0] port_in  = ~sel_q & ~dir_q;
    wire [NPINS-1:0] dat_view = (port_in & pin_s) | (~port_in & dat_q);

    // read mux
    wire [15:0] rd_mux = hit_sel ? 16'(sel_q) :
                         hit_dir ? 16'(dir_q) :
                         hit_dat ? 16'(dat_view) : 16'h0000;

    // ************************************************************
    // register writes
    // ************************************************************
    // each register updates per byte lane on a mapped write
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sel_q <= NPINS'(RST_PIN_FUNCTION_SELECT);
            dir_q <= NPINS'(RST_PORT_DIRECTION);
            dat_q <= NPINS'(RST_PORT_DATA);
        end else if (wr_en) begin
            if (hit_sel) begin
                // per-bit select, every pin independent
                sel_q <= NPINS'((16'(sel_q) & ~be_mask) | (i_reg_wdata & be_mask));
            end
            if (hit_dir) begin
                dir_q <= NPINS'((16'(dir_q) & ~be_mask) | (i_reg_wdata & be_mask));
            end
            if (hit_dat) begin
                // written regardless of direction or function
                dat_q <= NPINS'((16'(dat_q) & ~be_mask) | (i_reg_wdata & be_mask));
            end
        end
    end

    // ************************************************************
    // bus answer
    // ************************************************************
    // one cycle answer after each selected access
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            ack_q   <= i_reg_sel & hit_any;
            err_q   <= i_reg_sel & ~hit_any;
            // reads capture data; else hold last value
            if (rd_en) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign o_reg_ack   = ack_q;
    assign o_reg_err   = err_q;
    assign o_reg_rdata = rdata_q;

    // ************************************************************
    // transfer in progress
    // ************************************************************
    // high the cycle after a transfer cycle, low the cycle after an idle one
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tip_q <= 1'b0;
        end else begin
            tip_q <= i_bus_xfer_active;
        end
    end

    // ************************************************************
    // alternate function values, one bit per pin
    // ************************************************************
    // transfer modifier: low on cpu space, level on interrupt ack
    wire [2:0] tmod = i_int_ack   ? i_int_level :
                      i_cpu_space ? TMOD_CPU_SPACE : i_xfer_modifier;
    // two modifier lines may act as dma acknowledges
    wire [2:0] tmod_out = {tmod[2],
                           i_dma_ack_en[1] ? i_dma_ack[1] : tmod[1],
                           i_dma_ack_en[0] ? i_dma_ack[0] : tmod[0]};

    // alternate output values and enables
    wire [15:0] alt_val = {i_alt_addr_hi, tip_q, 2'b00, tmod_out, i_xfer_type};
    wire [15:0] alt_oe  = {8'hFF,
                           i_bus_owned,
                           2'b00,
                           3'b111,
                           {2{i_bus_master}}};

    // ************************************************************
    // pin drivers
    // ************************************************************
    // select bit picks port or alternate function per pin
    wire [NPINS-1:0] port_oe = ~sel_q & dir_q;
    assign o_port_pin    = (sel_q & NPINS'(alt_val)) |
                           (~sel_q & dat_q);
    assign o_port_pin_oe = (sel_q & NPINS'(alt_oe)) | port_oe;

    // dma request inputs, active only while selected
    assign o_dma_request_in = {pin_s[FLD_DMA_REQUEST_IN_LSB] & sel_q[FLD_DMA_REQUEST_IN_LSB],
                               pin_s[FLD_DMA_REQUEST_IN_LSB+1] & sel_q[FLD_DMA_REQUEST_IN_LSB+1]};

    assign o_pin_function_select = sel_q;
endmodule
`default_nettype wire

/* hdl/mppio_pkg.sv */
// ****************************************************************
// parallel port constants
// ****************************************************************
package mppio_pkg;
    // number of multiplexed pins
    localparam int unsigned PIN_COUNT = 16;
    // register offsets from the module base address
    localparam logic [11:0] OFS_PIN_FUNCTION_SELECT = 12'h004;
    localparam logic [11:0] OFS_PORT_DIRECTION      = 12'h244;
    localparam logic [11:0] OFS_PORT_DATA           = 12'h248;
    // reset values
    localparam logic [15:0] RST_PIN_FUNCTION_SELECT = 16'h0000;
    localparam logic [15:0] RST_PORT_DIRECTION      = 16'h0000;
    localparam logic [15:0] RST_PORT_DATA           = 16'h0000;
    // field positions inside the function select word
    localparam int unsigned FLD_ADDR_LSB   = 8;
    localparam int unsigned FLD_TIP        = 7;
    localparam int unsigned FLD_DMA_REQUEST_IN_LSB   = 5;
    localparam int unsigned FLD_TMOD_LSB   = 2;
    localparam int unsigned FLD_TTYPE_LSB  = 0;
    // transfer modifier value during cpu space transfers
    localparam logic [2:0]  TMOD_CPU_SPACE = 3'h0;
    // synchroniser depth
    localparam int unsigned SYNC_STAGES    = 2;
endpackage

/* hdl/mppio_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// two-flop level synchroniser, one bit
// ****************************************************************
module mppio_sync (
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_q; // first stage, read only by the second
    logic sync_q; // second stage

    // two stage shift
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

/* dv/mppio_port_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// port checker, bound to the top module
// ****************************************
module mppio_port_asserts
    import mppio_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire logic        i_reg_sel,
    input wire logic [11:0] i_reg_addr,
    input wire logic        o_reg_ack,
    input wire logic        o_reg_err,
    input wire logic [7:0]  i_alt_addr_hi,
    input wire logic        i_bus_xfer_active,
    input wire logic        i_cpu_space,
    input wire logic        i_int_ack,
    input wire logic [2:0]  i_int_level,
    input wire logic [1:0]  i_dma_ack_en,
    input wire logic [1:0]  i_xfer_type,
    input wire logic [15:0] o_pin_function_select,
    input wire logic [15:0] o_port_pin,
    input wire logic [15:0] o_port_pin_oe
);
    wire logic [15:0] fs = o_pin_function_select; // current select word
    // offset hits one of the three registers
    wire logic mapped = i_reg_addr inside {OFS_PIN_FUNCTION_SELECT, OFS_PORT_DIRECTION,
                                           OFS_PORT_DATA};
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_map;
        i_reg_sel && mapped;
    endsequence
    a_ack_next: assert property (s_map |=> o_reg_ack && !o_reg_err)
        else $error("mapped access not acknowledged");
    a_err_next: assert property (i_reg_sel && !mapped |=> o_reg_err && !o_reg_ack)
        else $error("unmapped access not refused");
    a_no_spurious: assert property (!i_reg_sel |=> !o_reg_ack && !o_reg_err)
        else $error("answer without request");
    a_alt_addr: assert property (((o_port_pin[15:8] ^ i_alt_addr_hi) & fs[15:8]) == 8'h00
        && (o_port_pin_oe[15:8] & fs[15:8]) == fs[15:8]) else $error("address pins wrong");
    a_xfer_follow: assert property (fs[7] && $past(!i_srst) |->
        o_port_pin[7] == $past(i_bus_xfer_active)) else $error("transfer pin wrong");
    a_dma_request_in_input: assert property ((o_port_pin_oe[6:5] & fs[6:5]) == 2'h0)
        else $error("request pin driven");
    a_cpu_space: assert property ((&fs[4:2]) && i_cpu_space && !i_int_ack
        && i_dma_ack_en == 2'h0 |-> o_port_pin[4:2] == TMOD_CPU_SPACE) else $error("modifier");
    a_iack_level: assert property ((&fs[4:2]) && i_int_ack && !i_cpu_space
        && i_dma_ack_en == 2'h0 |-> o_port_pin[4:2] == i_int_level) else $error("level");
    a_ttype_out: assert property (((o_port_pin[1:0] ^ i_xfer_type) & fs[1:0]) == 2'h0)
        else $error("transfer type pins wrong");
endmodule
bind mppio_port mppio_port_asserts u_chk (.*);
`default_nettype wire

/* dv/test_multiplexed_parallel_io_port.sv */
`timescale 1ns/1ns
`default_nettype none
module test_multiplexed_parallel_io_port;
    import mppio_pkg::*;
    logic        i_clk, i_srst, i_reg_sel, i_reg_wr, i_bus_xfer_active, i_bus_owned;
    logic        i_cpu_space, i_int_ack, i_bus_master, o_reg_ack, o_reg_err;
    logic [1:0]  i_reg_be, i_dma_ack_en, i_dma_ack, i_xfer_type, o_dma_request_in;
    logic [2:0]  i_int_level, i_xfer_modifier;
    logic [7:0]  i_alt_addr_hi;
    logic [11:0] i_reg_addr;
    logic [15:0] i_reg_wdata, o_reg_rdata, o_pin_function_select;
    logic [15:0] i_port_pin, o_port_pin, o_port_pin_oe;
    int          failures = 0;
    int          checks = 0;
    mppio_port dut (.*);
    // 50 ns clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one request cycle, outputs looked at just after the answering edge
    task automatic access(input logic wr, input logic [11:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_reg_sel <= 1'b1;
        i_reg_wr <= wr;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_sel <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        access(1'b1, a, d);
        check("ack", {15'h0, o_reg_ack}, 16'h1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        access(1'b0, a, 16'h0);
        check("rdata", o_reg_rdata, exp);
    endtask
    // hang guard, runs far longer than the tests
    initial begin
        repeat (2000) @(posedge i_clk);
        failures++;
        report_and_stop();
    end
    initial begin
        {i_reg_sel, i_reg_wr, i_bus_xfer_active, i_cpu_space, i_int_ack} = '0;
        {i_dma_ack_en, i_dma_ack, i_xfer_type, i_int_level, i_xfer_modifier} = '0;
        {i_reg_addr, i_reg_wdata, i_alt_addr_hi} = '0;
        {i_bus_owned, i_bus_master, i_reg_be, i_srst} = 5'h1F;
        i_port_pin = 16'h3C3C;
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        #1 check("oe", o_port_pin_oe, RST_PORT_DIRECTION);
        rd(OFS_PIN_FUNCTION_SELECT, RST_PIN_FUNCTION_SELECT);
        rd(OFS_PORT_DIRECTION, RST_PORT_DIRECTION);
        rd(OFS_PORT_DATA, 16'h3C3C);
        access(1'b0, 12'h100, 16'h0);
        check("err", {15'h0, o_reg_err}, 16'h1);
        check("rdata", o_reg_rdata, 16'h0);
        $display("test reset and refusal done");
        wr(OFS_PORT_DATA, 16'hA5A5);
        check("oe", o_port_pin_oe, 16'h0);
        rd(OFS_PORT_DATA, 16'h3C3C);
        wr(OFS_PORT_DIRECTION, 16'hFFFF);
        check("pins", o_port_pin, 16'hA5A5);
        check("oe", o_port_pin_oe, 16'hFFFF);
        rd(OFS_PORT_DATA, 16'hA5A5);
        $display("test port directions done");
        i_alt_addr_hi <= 8'h96;
        i_xfer_type <= 2'h2;
        i_cpu_space <= 1'b1;
        i_bus_xfer_active <= 1'b1;
        wr(OFS_PIN_FUNCTION_SELECT, 16'hFFFF);
        check("select", o_pin_function_select, 16'hFFFF);
        check("addr", {8'h0, o_port_pin[15:8]}, 16'h0096);
        check("xfer", {15'h0, o_port_pin[7]}, 16'h1);
        check("dma_request_in oe", {14'h0, o_port_pin_oe[6:5]}, 16'h0);
        check("dma_request_in", {14'h0, o_dma_request_in}, 16'h2);
        check("modifier", {13'h0, o_port_pin[4:2]}, 16'h0);
        check("type", {14'h0, o_port_pin[1:0]}, 16'h2);
        rd(OFS_PORT_DATA, 16'hA5A5);
        i_cpu_space <= 1'b0;
        i_int_ack <= 1'b1;
        i_int_level <= 3'h5;
        i_bus_xfer_active <= 1'b0;
        @(posedge i_clk);
        #1 check("level", {13'h0, o_port_pin[4:2]}, 16'h5);
        check("xfer", {15'h0, o_port_pin[7]}, 16'h0);
        $display("test alternate functions done");
        wr(OFS_PIN_FUNCTION_SELECT, 16'h0300);
        check("pins", {8'h0, o_port_pin[15:8]}, 16'h00A6);
        wr(OFS_PORT_DIRECTION, 16'h0000);
        check("oe", o_port_pin_oe, 16'h0300);
        $display("test mixed upper pins done");
        report_and_stop();
    end
endmodule
`default_nettype wire
